/* hw/qsrot_pkg.sv */
// qsrot_pkg: shared constants for the serdes receive output and transmit enable block
package qsrot_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int AW = 8;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] TXEN_OFS = 8'h04;
	localparam logic [7:0] RXSEL_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DUAL_BIT = 2;
	localparam int CTRL_CODEC_BIT = 3;
	localparam int TXEN_PRI_LSB = 0;
	localparam int TXEN_RED_LSB = 4;
	localparam int RXSEL_LB_LSB = 0;
	localparam int RXSEL_SRC_LSB = 4;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] CTRL_RST = 32'h0000_0008;
	localparam logic [31:0] TXEN_RST = 32'h0000_0000;
	localparam logic [31:0] RXSEL_RST = 32'h0000_00F0;
	// ------------------------------------------------------------
	// receive timing modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		QSROT_TM_REF = 2'b00,
		QSROT_TM_OWN = 2'b01,
		QSROT_TM_CHA = 2'b10,
		QSROT_TM_RSV = 2'b11
	} qsrot_tmode_e;
endpackage

/* hw/qsrot_top.sv */
// qsrot_top: receive byte/flag output timing, recovered clock outputs, tx drivers, rx source select
// Overview of operation
// R1: primary tx data driven only when enabled
// R2: redundant tx data driven only when enabled
// R3: primary pair undriven when enable low
// R4: redundant pair undriven when enable low
// R5: rx byte timed to recovered or reference
// R6: one timing select for all outputs
// R7: idle flag, or comma detect if codec off
// R8: special flag, or raw bit 8 if codec off
// R9: error flag, or raw bit 9 if codec off
// R10: recovered clock from A or own, dual-rate
// R11: unused recovered clock: true low, inverted high
// R12: primary input when no loopback and select high
// R13: redundant input when no loopback and select low
// R14: flags change with their byte
// R15: downstream samples on selected reference, drops errors
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
module qsrot_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic recovered_clock,
	input wire logic [3:0] dec_valid,
	input wire logic [31:0] dec_byte,
	input wire logic [3:0] dec_idle,
	input wire logic [3:0] dec_special,
	input wire logic [3:0] dec_error,
	input wire logic [3:0] comma_detect_flag,
	input wire logic [3:0] raw_rx_bit8,
	input wire logic [3:0] raw_rx_bit9,
	input wire logic [3:0] primary_signal_detect,
	input wire logic [3:0] redundant_signal_detect,
	input wire logic [3:0] tx_skew_buffer_error,
	input wire logic [3:0] tx_serial_data,
	input wire logic [3:0] primary_serial_in,
	input wire logic [3:0] redundant_serial_in,
	output logic [31:0] rx_byte,
	output logic [3:0] idle_flag,
	output logic [3:0] special_char_flag,
	output logic [3:0] decode_error_flag,
	output logic [3:0] rx_clock_out,
	output logic [3:0] rx_clock_out_inverted,
	output logic [3:0] primary_detect_out,
	output logic [3:0] redundant_detect_out,
	output logic [3:0] skew_error_out,
	output logic [3:0] primary_serial_out_p,
	output logic [3:0] primary_serial_out_n,
	output logic [3:0] primary_serial_out_oe,
	output logic [3:0] redundant_serial_out_p,
	output logic [3:0] redundant_serial_out_n,
	output logic [3:0] redundant_serial_out_oe,
	output logic [3:0] rx_serial_selected
);
	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	qsrot_pkg::qsrot_tmode_e tmode;
	logic dual_rate, codec_en, setup, wr_go, hit;
	logic [3:0] pri_en, red_en, lb_hi, src_sel;
	logic [31:0] rd_mux;

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	assign setup = psel & ~penable;
	assign wr_go = psel & penable & pready & pwrite;
	always_comb
	begin
		hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			qsrot_pkg::CTRL_OFS: rd_mux = {28'h000_0000, codec_en, dual_rate, tmode};
			qsrot_pkg::TXEN_OFS: rd_mux = {24'h00_0000, red_en, pri_en};
			qsrot_pkg::RXSEL_OFS: rd_mux = {24'h00_0000, src_sel, lb_hi};
			qsrot_pkg::STAT_OFS: rd_mux = {16'h0000, decode_error_flag, skew_error_out,
				redundant_detect_out, primary_detect_out};
			default: hit = 1'b0;
		endcase
	end

	// zero wait states: answer is registered during the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~hit;
			prdata <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tmode <= qsrot_pkg::qsrot_tmode_e'(qsrot_pkg::CTRL_RST[qsrot_pkg::CTRL_MODE_LSB +: 2]);
			dual_rate <= qsrot_pkg::CTRL_RST[qsrot_pkg::CTRL_DUAL_BIT];
			codec_en <= qsrot_pkg::CTRL_RST[qsrot_pkg::CTRL_CODEC_BIT];
		end
		else if (wr_go && paddr == qsrot_pkg::CTRL_OFS)
		begin
			tmode <= qsrot_pkg::qsrot_tmode_e'(pwdata[qsrot_pkg::CTRL_MODE_LSB +: 2]);
			dual_rate <= pwdata[qsrot_pkg::CTRL_DUAL_BIT];
			codec_en <= pwdata[qsrot_pkg::CTRL_CODEC_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pri_en <= qsrot_pkg::TXEN_RST[qsrot_pkg::TXEN_PRI_LSB +: 4];
			red_en <= qsrot_pkg::TXEN_RST[qsrot_pkg::TXEN_RED_LSB +: 4];
		end
		else if (wr_go && paddr == qsrot_pkg::TXEN_OFS)
		begin
			pri_en <= pwdata[qsrot_pkg::TXEN_PRI_LSB +: 4];
			red_en <= pwdata[qsrot_pkg::TXEN_RED_LSB +: 4];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lb_hi <= qsrot_pkg::RXSEL_RST[qsrot_pkg::RXSEL_LB_LSB +: 4];
			src_sel <= qsrot_pkg::RXSEL_RST[qsrot_pkg::RXSEL_SRC_LSB +: 4];
		end
		else if (wr_go && paddr == qsrot_pkg::RXSEL_OFS)
		begin
			lb_hi <= pwdata[qsrot_pkg::RXSEL_LB_LSB +: 4];
			src_sel <= pwdata[qsrot_pkg::RXSEL_SRC_LSB +: 4];
		end
	end

	// ------------------------------------------------------------
	// recovered clock domain: word capture
	// ------------------------------------------------------------
	logic [31:0] hold_byte;
	logic [3:0] hold_idle, hold_k, hold_err, hold_comma, hold_b8, hold_b9, tog;

	// hold stays stable until the next word; the toggle tells pclk it is safe
	always_ff @(posedge recovered_clock or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_byte <= 32'h0000_0000;
			hold_idle <= 4'h0;
			hold_k <= 4'h0;
			hold_err <= 4'h0;
			hold_comma <= 4'h0;
			hold_b8 <= 4'h0;
			hold_b9 <= 4'h0;
			tog <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < qsrot_pkg::NUM_CH; i++)
				if (dec_valid[i])
				begin
					hold_byte[i*8 +: 8] <= dec_byte[i*8 +: 8];
					hold_idle[i] <= dec_idle[i];
					hold_k[i] <= dec_special[i];
					hold_err[i] <= dec_error[i];
					hold_comma[i] <= comma_detect_flag[i];
					hold_b8[i] <= raw_rx_bit8[i];
					hold_b9[i] <= raw_rx_bit9[i];
					tog[i] <= ~tog[i];
				end
		end
	end

	// ------------------------------------------------------------
	// synchronisers into pclk
	// ------------------------------------------------------------
	logic [3:0] tog_s1, tog_s2, tog_s3, ev, present, pri_in_s, red_in_s, rise;
	logic [19:0] pin_s1, pin_s2;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tog_s1 <= 4'h0;
			tog_s2 <= 4'h0;
			tog_s3 <= 4'h0;
			pin_s1 <= 20'h0_0000;
			pin_s2 <= 20'h0_0000;
		end
		else
		begin
			tog_s1 <= tog;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
			pin_s1 <= {redundant_serial_in, primary_serial_in, tx_skew_buffer_error,
				redundant_signal_detect, primary_signal_detect};
			pin_s2 <= pin_s1;
		end
	end

	assign ev = tog_s2 ^ tog_s3;
	assign pri_in_s = pin_s2[15:12];
	assign red_in_s = pin_s2[19:16];

	// every byte, flag and status output of a channel moves on the same present strobe; mode 2 follows channel a
	assign present = (tmode == qsrot_pkg::QSROT_TM_CHA) ? {4{ev[0]}} : ev; // R6 R10

	// ------------------------------------------------------------
	// receive byte, flags and status outputs
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_byte <= 32'h0000_0000;
			idle_flag <= 4'h0;
			special_char_flag <= 4'h0;
			decode_error_flag <= 4'h0;
			primary_detect_out <= 4'h0;
			redundant_detect_out <= 4'h0;
			skew_error_out <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < qsrot_pkg::NUM_CH; i++)
				if (present[i])
				begin
					rx_byte[i*8 +: 8] <= hold_byte[i*8 +: 8]; // R5
					idle_flag[i] <= codec_en ? hold_idle[i] : hold_comma[i]; // R7 R14
					special_char_flag[i] <= codec_en ? hold_k[i] : hold_b8[i]; // R8 R14
					decode_error_flag[i] <= codec_en ? hold_err[i] : hold_b9[i]; // R9 R14
					primary_detect_out[i] <= pin_s2[i]; // R6
					redundant_detect_out[i] <= pin_s2[4 + i]; // R6
					skew_error_out[i] <= pin_s2[8 + i]; // R6
				end
		end
	end

	// ------------------------------------------------------------
	// recovered clock outputs
	// ------------------------------------------------------------
	// single rate: low while data changes, high one cycle later
	// dual rate: toggle one cycle after the data so no edge meets a data change
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_clock_out <= 4'h0;
			rx_clock_out_inverted <= 4'hF;
			rise <= 4'h0;
		end
		else
		begin
			for (int i = 0; i < qsrot_pkg::NUM_CH; i++)
				if (tmode == qsrot_pkg::QSROT_TM_REF)
				begin
					rx_clock_out[i] <= 1'b0; // R11
					rx_clock_out_inverted[i] <= 1'b1; // R11
					rise[i] <= 1'b0;
				end
				else if (present[i])
				begin
					rx_clock_out[i] <= rx_clock_out[i] & dual_rate; // R10
					rx_clock_out_inverted[i] <= ~(rx_clock_out[i] & dual_rate);
					rise[i] <= 1'b1;
				end
				else if (rise[i])
				begin
					rx_clock_out[i] <= ~rx_clock_out[i] | ~dual_rate; // R10
					rx_clock_out_inverted[i] <= rx_clock_out[i] & dual_rate;
					rise[i] <= 1'b0;
				end
		end
	end

	// ------------------------------------------------------------
	// transmit drivers and receive source select
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			primary_serial_out_p <= 4'h0;
			primary_serial_out_n <= 4'h0;
			primary_serial_out_oe <= 4'h0;
			redundant_serial_out_p <= 4'h0;
			redundant_serial_out_n <= 4'h0;
			redundant_serial_out_oe <= 4'h0;
		end
		else
		begin
			primary_serial_out_p <= tx_serial_data & pri_en; // R1
			primary_serial_out_n <= ~tx_serial_data & pri_en; // R1
			primary_serial_out_oe <= pri_en; // R3
			redundant_serial_out_p <= tx_serial_data & red_en; // R2
			redundant_serial_out_n <= ~tx_serial_data & red_en; // R2
			redundant_serial_out_oe <= red_en; // R4
		end
	end

	// lower-nibble loopback bit set feeds the channel its own tx stream
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_serial_selected <= 4'h0;
		else
			rx_serial_selected <= (lb_hi & tx_serial_data)
				| (~lb_hi & src_sel & pri_in_s) // R12
				| (~lb_hi & ~src_sel & red_in_s); // R13
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	pri_tx_data_a: assert property (pri_en[0] |=> primary_serial_out_p[0] == $past(tx_serial_data[0])
		&& primary_serial_out_n[0] != primary_serial_out_p[0]) else $error("primary tx data wrong"); // R1
	red_tx_data_a: assert property (red_en[3] |=> redundant_serial_out_p[3] == $past(tx_serial_data[3])
		&& redundant_serial_out_oe[3]) else $error("redundant tx data wrong"); // R2
	pri_tx_off_a: assert property ((!pri_en[1])[*2] |-> !primary_serial_out_oe[1]
		&& !primary_serial_out_p[1] && !primary_serial_out_n[1]) else $error("primary pair driven"); // R3
	red_tx_off_a: assert property ((!red_en[2])[*2] |-> !redundant_serial_out_oe[2]
		&& !redundant_serial_out_p[2]) else $error("redundant pair driven"); // R4
	rx_byte_hold_a: assert property (present == 4'h0 |=> $stable(rx_byte))
		else $error("rx byte moved without word"); // R5
	common_timing_a: assert property (tmode == qsrot_pkg::QSROT_TM_CHA && ev[0] |-> present == 4'hF)
		else $error("channels not on channel A timing"); // R6
	idle_comma_a: assert property (present[0] && !codec_en |=> idle_flag[0] == $past(hold_comma[0]))
		else $error("idle output not comma detect"); // R7
	special_raw_a: assert property (present[1] && !codec_en |=> special_char_flag[1] == $past(hold_b8[1]))
		else $error("special output not raw bit 8"); // R8
	error_flag_a: assert property (present[2] && codec_en |=> decode_error_flag[2] == $past(hold_err[2]))
		else $error("error flag not from decoder"); // R9
	clk_single_a: assert property (tmode != qsrot_pkg::QSROT_TM_REF && !dual_rate && present[0]
		&& $stable(tmode) |=> !rx_clock_out[0] ##1 rx_clock_out[0] && !rx_clock_out_inverted[0])
		else $error("recovered clock pulse wrong"); // R10
	clk_unused_a: assert property (tmode == qsrot_pkg::QSROT_TM_REF |=> rx_clock_out == 4'h0
		&& rx_clock_out_inverted == 4'hF) else $error("unused clock pair not parked"); // R11
	src_select_a: assert property (!lb_hi[0] |=> rx_serial_selected[0]
		== $past(src_sel[0] ? pri_in_s[0] : red_in_s[0])) else $error("rx source wrong"); // R12 R13
	flag_align_a: assert property (!$stable({idle_flag, special_char_flag, decode_error_flag})
		|-> $past(|present)) else $error("flag moved apart from byte"); // R14

	cover property (tmode == qsrot_pkg::QSROT_TM_CHA && present[3]);
	cover property (dual_rate && present[1] ##1 rx_clock_out[1]);
	cover property (!codec_en && present[0] ##1 idle_flag[0]);
	cover property (!lb_hi[2] && !src_sel[2] ##1 rx_serial_selected[2]);
endmodule // qsrot_top

/* dv/qsrot_downstream.sv */
// qsrot_downstream: downstream sampler keeping the last error-free byte of each lane
`timescale 1ns/1ps
module qsrot_downstream
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] rx_byte,
	input wire logic [3:0] decode_error_flag,
	output logic [31:0] good_byte
);
	// samples on the reference clock, drops bytes marked bad
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			good_byte <= 32'h0;
		else
			for (int i = 0; i < 4; i++)
				if (!decode_error_flag[i])
					good_byte[8*i +: 8] <= rx_byte[8*i +: 8];
	end
endmodule // qsrot_downstream

/* dv/tb_quad_serdes_rx_output_tx_enable.sv */
// tb_quad_serdes_rx_output_tx_enable: register, tx driver, rx select and receive word tests
`timescale 1ns/1ps
module tb_quad_serdes_rx_output_tx_enable;
	logic pclk, rclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rx_byte, good_byte, rd, db;
	logic [3:0] dv, idl, spc, der, com, b8, b9, psd, rsd, tbe, txd, pin, rin;
	logic [3:0] ifl, sfl, efl, rco, rcon, pdo, rdo, seo, pp, pn, poe, rp, rn, roe, sel, seen;
	int errors, checks_done, cyc;

	qsrot_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.recovered_clock(rclk), .dec_valid(dv), .dec_byte(db), .dec_idle(idl), .dec_special(spc),
		.dec_error(der), .comma_detect_flag(com), .raw_rx_bit8(b8), .raw_rx_bit9(b9),
		.primary_signal_detect(psd), .redundant_signal_detect(rsd), .tx_skew_buffer_error(tbe),
		.tx_serial_data(txd), .primary_serial_in(pin), .redundant_serial_in(rin), .rx_byte(rx_byte),
		.idle_flag(ifl), .special_char_flag(sfl), .decode_error_flag(efl), .rx_clock_out(rco),
		.rx_clock_out_inverted(rcon), .primary_detect_out(pdo), .redundant_detect_out(rdo),
		.skew_error_out(seo), .primary_serial_out_p(pp), .primary_serial_out_n(pn),
		.primary_serial_out_oe(poe), .redundant_serial_out_p(rp), .redundant_serial_out_n(rn),
		.redundant_serial_out_oe(roe), .rx_serial_selected(sel));
	qsrot_downstream down (.pclk(pclk), .presetn(presetn), .rx_byte(rx_byte), .decode_error_flag(efl),
		.good_byte(good_byte));

	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	// link clock, free running like a recovered clock
	initial
	begin
		rclk = 1'h0;
		#3;
		forever #6 rclk = ~rclk;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// no local timeout: only pready or the bench timeout ends a wait
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	// one word on every lane; data lines scrambled once the strobe drops
	task automatic word(input logic [31:0] b, input logic [3:0] e);
		@(posedge rclk);
		dv <= 4'hF;
		db <= b;
		der <= e;
		@(posedge rclk);
		dv <= 4'h0;
		db <= ~b;
		der <= ~e;
		seen = 4'h0;
		repeat (10)
		begin
			@(posedge pclk);
			seen = seen | rco;
		end
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			end_sim;
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		presetn = 1'h0;
		{psel, penable, pwrite, paddr, pwdata, dv, db, der} = '0;
		idl = 4'h1;
		spc = 4'h2;
		com = 4'h4;
		b8 = 4'h8;
		b9 = 4'h3;
		psd = 4'h3;
		rsd = 4'hC;
		tbe = 4'h5;
		txd = 4'hA;
		pin = 4'h5;
		rin = 4'hC;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk("clk_n_reset", rcon, 32'hF);
		rdchk("ctrl_rst", qsrot_pkg::CTRL_OFS, qsrot_pkg::CTRL_RST);
		rdchk("txen_rst", qsrot_pkg::TXEN_OFS, qsrot_pkg::TXEN_RST);
		rdchk("rxsel_rst", qsrot_pkg::RXSEL_OFS, qsrot_pkg::RXSEL_RST);
		rdchk("unmapped", 8'h10, 32'h0);
		chk("unmapped_err", err, 32'h1);
		chk("sel_pri", sel, 32'h5);
		apb(1'h1, qsrot_pkg::TXEN_OFS, 32'h0F);
		repeat (3) @(posedge pclk);
		chk("pri_on", {poe, pp}, 32'hFA);
		chk("red_off", {roe, rp, rn}, 32'h0);
		apb(1'h1, qsrot_pkg::TXEN_OFS, 32'hF0);
		repeat (3) @(posedge pclk);
		chk("pri_off", {poe, pp, pn}, 32'h0);
		chk("red_on", {roe, rp}, 32'hFA);
		apb(1'h1, qsrot_pkg::RXSEL_OFS, 32'h00);
		repeat (4) @(posedge pclk);
		chk("sel_red", sel, 32'hC);
		// loopback on lanes 0 and 1 overrides the pin choice there
		apb(1'h1, qsrot_pkg::RXSEL_OFS, 32'hF3);
		repeat (4) @(posedge pclk);
		chk("sel_loop", sel, 32'h6);
		word(32'h11223344, 4'h0);
		chk("rx_byte_ref", rx_byte, 32'h11223344);
		chk("flags_dec", {ifl, sfl, efl}, 32'h120);
		chk("status_ref", {pdo, rdo, seo}, 32'h3C5);
		chk("clk_parked", {seen, rcon}, 32'h0F);
		word(32'h55667788, 4'h2);
		chk("err_flag", efl, 32'h2);
		rdchk("stat", qsrot_pkg::STAT_OFS, 32'h25C3);
		chk("good_byte", good_byte, 32'h55663388);
		apb(1'h1, qsrot_pkg::CTRL_OFS, 32'h0);
		word(32'h99AABBCC, 4'hF);
		chk("flags_raw", {ifl, sfl, efl}, 32'h483);
		apb(1'h1, qsrot_pkg::CTRL_OFS, 32'h9);
		word(32'h01020304, 4'h0);
		chk("rx_byte_own", rx_byte, 32'h01020304);
		chk("clk_running", seen, 32'hF);
		// channel a timing at half rate, codec off: the pair toggles once per word
		apb(1'h1, qsrot_pkg::CTRL_OFS, 32'h6);
		word(32'hA55A0FF0, 4'h0);
		chk("rx_byte_cha", rx_byte, 32'hA55A0FF0);
		chk("clk_dual_lo", {rco, rcon}, 32'h0F);
		word(32'h13579BDF, 4'h0);
		chk("flags_cha", {ifl, sfl, efl}, 32'h483);
		chk("clk_dual_hi", {rco, rcon}, 32'hF0);
		apb(1'h1, qsrot_pkg::CTRL_OFS, 32'hB);
		word(32'h2468ACE0, 4'h0);
		chk("rx_byte_own3", rx_byte, 32'h2468ACE0);
		chk("clk_own3", {seen, rco, rcon}, 32'hFF0);
		end_sim;
	end
endmodule // tb_quad_serdes_rx_output_tx_enable
